// File: hw/vpe_pkg.sv
// package of constants and types for the voice pitch and envelope block
package vpe_pkg;

    // ==========================================================
    // clock figures
    localparam int unsigned MCLK_HZ       = 250_000_000;  // system clock rate
    localparam int unsigned OSC_CLK_HZ    = 1_000_000;    // oscillator master clock rate
    localparam int unsigned OSC_DIV       = MCLK_HZ / OSC_CLK_HZ;  // mclk cycles per osc tick
    localparam int unsigned NS_PER_MS     = 1_000_000;    // nanoseconds in one millisecond
    localparam int unsigned MCLK_NS       = 4;            // mclk period in ns
    localparam int unsigned MS_CYCLES     = NS_PER_MS / MCLK_NS;  // mclk cycles per ms

    // ==========================================================
    // widths
    localparam int unsigned FREQ_W        = 16;   // frequency word width
    localparam int unsigned ACC_W         = 24;   // phase accumulator width
    localparam int unsigned PHASE_W       = 12;   // phase bits shown outside
    localparam int unsigned LEVEL_W       = 8;    // envelope level width
    localparam int unsigned CODE_W        = 4;    // rate or sustain code width
    localparam int unsigned ADDR_W        = 4;    // register address width
    localparam int unsigned DATA_W        = 8;    // register data width
    localparam int unsigned STEPS         = 255;  // level steps from zero to peak
    localparam int unsigned DR_SCALE      = 3;    // decay and release run three times slower

    // ==========================================================
    // register offsets
    localparam logic [3:0] REG_FREQ_LO    = 4'h0;  // frequency word low byte
    localparam logic [3:0] REG_FREQ_HI    = 4'h1;  // frequency word high byte
    localparam logic [3:0] REG_CTRL       = 4'h2;  // key-on control
    localparam logic [3:0] REG_ATK_DEC    = 4'h3;  // attack and decay codes
    localparam logic [3:0] REG_SUS_REL    = 4'h4;  // sustain level and release code
    localparam logic [3:0] REG_LEVEL      = 4'h5;  // present envelope level, read only
    localparam logic [3:0] REG_PHASE      = 4'h6;  // oscillator phase top byte, read only
    localparam logic [3:0] REG_STATE      = 4'h7;  // envelope phase code, read only

    // ==========================================================
    // field positions
    localparam int unsigned CTRL_KEY_BIT  = 0;  // key-on bit in control
    localparam int unsigned HI_NIB_LSB    = 4;  // attack / sustain nibble
    localparam int unsigned LO_NIB_LSB    = 0;  // decay / release nibble

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BYTE       = 8'h00;   // all settings clear
    localparam logic [7:0] RST_LEVEL      = 8'h00;   // envelope silent
    localparam logic [7:0] PEAK_LEVEL     = 8'hff;   // envelope peak
    localparam logic [7:0] ZERO_LEVEL     = 8'h00;   // silence

    // ==========================================================
    // attack time in ms per rate code; decay and release take three times this
    localparam int unsigned ATK_MS [16] = '{
        2, 8, 16, 24, 38, 56, 68, 80, 100, 250, 500, 800, 1000, 3000, 5000, 8000
    };

    // ==========================================================
    // envelope phases, one-hot
    typedef enum logic [4:0] {
        VPE_IDLE    = 5'h01,
        VPE_ATTACK  = 5'h02,
        VPE_DECAY   = 5'h04,
        VPE_SUSTAIN = 5'h08,
        VPE_RELEASE = 5'h10
    } vpe_state_t;

endpackage : vpe_pkg

// File: hw/vpe_oscillator.sv
// phase accumulator oscillator stepped by a derived master clock tick
`timescale 1ns/10ps
module vpe_oscillator #(
    parameter int unsigned DIV = vpe_pkg::OSC_DIV  // mclk cycles per master tick
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic                          ce,
    // pitch control
    input  wire logic [vpe_pkg::FREQ_W-1:0]    freq_word,
    // phase out
    output logic      [vpe_pkg::ACC_W-1:0]     phase
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [15:0]                div;  // master tick divider
        logic [vpe_pkg::ACC_W-1:0]  acc;  // phase accumulator
    } vpe_osc_t;

    vpe_osc_t st;       // registered state
    vpe_osc_t next_st;  // next state

    // ==========================================================
    // accumulate the word once per master tick; pitch is word * fclk / 2^24
    always_comb begin
        next_st = st;
        if (st.div == 16'(DIV - 1)) begin
            next_st.div = 16'h0000;
            next_st.acc = st.acc + vpe_pkg::ACC_W'(freq_word);
        end else begin
            next_st.div = st.div + 16'h0001;
        end
    end

    // register, synchronous reset, frozen by clock enable
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign phase = st.acc;

endmodule : vpe_oscillator

// File: hw/vpe_rate_timer.sv
// step timer: one pulse every period cycles, restartable
`timescale 1ns/10ps
module vpe_rate_timer (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    // control
    input  wire logic        restart,
    input  wire logic [31:0] period,
    // output
    output logic             step
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0] cnt;   // cycles left to next step
        logic        step;  // step pulse
    } vpe_tmr_t;

    vpe_tmr_t st;       // registered state
    vpe_tmr_t next_st;  // next state

    // ==========================================================
    // count down; reload on restart or at zero
    always_comb begin
        next_st      = st;
        next_st.step = 1'b0;
        if (restart) begin
            next_st.cnt = period - 32'h1;
        end else if (st.cnt == 32'h0) begin
            next_st.cnt  = period - 32'h1;
            next_st.step = 1'b1;
        end else begin
            next_st.cnt = st.cnt - 32'h1;
        end
    end

    // register, synchronous reset, frozen by clock enable
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign step = st.step;

endmodule : vpe_rate_timer

// File: hw/vpe_voice.sv
// one voice: register port, pitch oscillator and four-phase envelope
//
// What this block does
// - 1 MHz clock: 3691 gives 220 Hz
// - pitch strictly linear in frequency word
// - attack 10, decay 8, release 9 timings
// - attack 0 about 2 ms, release 0 about 6 ms
// - attack to peak, decay to sustain, release
// - sustain holds until key-on bit clears
// - sustain zero decays to silence after peak
// - key-off during decay releases from present level
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module vpe_voice #(
    parameter int unsigned MS_CYC = vpe_pkg::MS_CYCLES,  // mclk cycles per millisecond
    parameter int unsigned DIV    = vpe_pkg::OSC_DIV     // mclk cycles per master tick
) (
    // clock, reset, enable
    input  wire logic                            mclk,
    input  wire logic                            reset_n,
    input  wire logic                            ce,
    // register port
    input  wire logic [vpe_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [vpe_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [vpe_pkg::DATA_W-1:0]      reg_rdata,
    // voice outputs
    output logic      [vpe_pkg::PHASE_W-1:0]     osc_phase,
    output logic      [vpe_pkg::LEVEL_W-1:0]     env_level,
    output logic                                 env_busy
);

    // ==========================================================
    // state of the voice
    typedef struct packed {
        logic [15:0]                   freq;      // frequency word
        logic                          key_on;    // key-on setting
        logic                          key_prev;  // key-on one cycle ago
        logic [3:0]                    atk;       // attack rate code
        logic [3:0]                    dec;       // decay rate code
        logic [3:0]                    sus;       // sustain level code
        logic [3:0]                    rel;       // release rate code
        vpe_pkg::vpe_state_t           phase;     // envelope phase
        logic [7:0]                    level;     // envelope level
        logic [7:0]                    rdata;     // read data
        logic [vpe_pkg::PHASE_W-1:0]   osc_out;   // oscillator phase shown outside
        logic                          busy;      // envelope not idle
    } vpe_voice_t;

    vpe_voice_t st;       // registered state
    vpe_voice_t next_st;  // next state

    // ==========================================================
    // oscillator
    logic [vpe_pkg::ACC_W-1:0] acc;  // accumulator value

    vpe_oscillator #(
        .DIV       (DIV)
    ) u_osc (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .ce        (ce),
        .freq_word (st.freq),
        .phase     (acc)
    );

    // ==========================================================
    // step period tables, one entry per rate code
    logic [31:0] atk_per [16];  // attack step period
    logic [31:0] dr_per  [16];  // decay and release step period

    for (genvar g = 0; g < 16; g++) begin : g_per
        // time spread evenly over the steps from zero to peak
        assign atk_per[g] = 32'((64'(vpe_pkg::ATK_MS[g]) * 64'(MS_CYC))
                               / 64'(vpe_pkg::STEPS));
        assign dr_per[g]  = 32'((64'(vpe_pkg::ATK_MS[g]) * 64'(MS_CYC)
                               * 64'(vpe_pkg::DR_SCALE))
                               / 64'(vpe_pkg::STEPS));
    end

    // ==========================================================
    // step timer; restarted on each phase change
    logic        step;      // one level step due
    logic        restart;   // phase changed
    logic [31:0] period;    // period for the present phase

    // pick the rate for the phase being entered or held
    always_comb begin
        unique case (next_st.phase)
            vpe_pkg::VPE_ATTACK:  period = atk_per[next_st.atk];
            vpe_pkg::VPE_DECAY:   period = dr_per[next_st.dec];
            vpe_pkg::VPE_RELEASE: period = dr_per[next_st.rel];
            default:              period = dr_per[next_st.rel];  // idle, sustain: no step
        endcase
    end

    assign restart = (next_st.phase != st.phase);

    vpe_rate_timer u_tmr (
        .mclk    (mclk),
        .reset_n (reset_n),
        .ce      (ce),
        .restart (restart),
        .period  (period),
        .step    (step)
    );

    // ==========================================================
    // registers and envelope sequencing
    logic [7:0] sus_level;  // sustain target, nibble repeated to full scale
    logic       key_rise;   // key-on just set
    logic       key_fall;   // key-on just cleared

    assign sus_level = {st.sus, st.sus};  // zero stays zero: silence

    assign key_rise = st.key_on & ~st.key_prev;
    assign key_fall = ~st.key_on & st.key_prev;

    always_comb begin
        next_st          = st;
        next_st.key_prev = st.key_on;
        next_st.osc_out  = acc[vpe_pkg::ACC_W-1 -: vpe_pkg::PHASE_W];

        // ------------------------------------------------------
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                vpe_pkg::REG_FREQ_LO: begin
                    next_st.freq[7:0] = reg_wdata;
                end
                vpe_pkg::REG_FREQ_HI: begin
                    next_st.freq[15:8] = reg_wdata;
                end
                vpe_pkg::REG_CTRL: begin
                    next_st.key_on = reg_wdata[vpe_pkg::CTRL_KEY_BIT];
                end
                vpe_pkg::REG_ATK_DEC: begin
                    next_st.atk = reg_wdata[vpe_pkg::HI_NIB_LSB +: 4];
                    next_st.dec = reg_wdata[vpe_pkg::LO_NIB_LSB +: 4];
                end
                vpe_pkg::REG_SUS_REL: begin
                    next_st.sus = reg_wdata[vpe_pkg::HI_NIB_LSB +: 4];
                    next_st.rel = reg_wdata[vpe_pkg::LO_NIB_LSB +: 4];
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end

        // ------------------------------------------------------
        // register reads: data stand in the next cycle only
        next_st.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                vpe_pkg::REG_FREQ_LO: next_st.rdata = st.freq[7:0];
                vpe_pkg::REG_FREQ_HI: next_st.rdata = st.freq[15:8];
                vpe_pkg::REG_CTRL:    next_st.rdata = {7'h00, st.key_on};
                vpe_pkg::REG_ATK_DEC: next_st.rdata = {st.atk, st.dec};
                vpe_pkg::REG_SUS_REL: next_st.rdata = {st.sus, st.rel};
                vpe_pkg::REG_LEVEL:   next_st.rdata = st.level;
                vpe_pkg::REG_PHASE:   next_st.rdata = acc[vpe_pkg::ACC_W-1 -: 8];
                vpe_pkg::REG_STATE:   next_st.rdata = {3'h0, st.phase};
                default:              next_st.rdata = 8'h00;  // unmapped reads zero
            endcase
        end

        // ------------------------------------------------------
        // key edges override any phase and keep the present level
        if (key_rise) begin
            next_st.phase = vpe_pkg::VPE_ATTACK;
        end else if (key_fall) begin
            next_st.phase = vpe_pkg::VPE_RELEASE;
        end else if (step) begin
            unique case (st.phase)
                // climb to peak, then head for the sustain level
                vpe_pkg::VPE_ATTACK: begin
                    if (st.level == vpe_pkg::PEAK_LEVEL) begin
                        next_st.phase = vpe_pkg::VPE_DECAY;
                    end else begin
                        next_st.level = st.level + 8'h01;
                    end
                end
                // fall to the sustain level; a zero level falls to silence
                vpe_pkg::VPE_DECAY: begin
                    if (st.level <= sus_level) begin
                        next_st.phase = vpe_pkg::VPE_SUSTAIN;
                    end else begin
                        next_st.level = st.level - 8'h01;
                    end
                end
                // hold as long as the key stays on
                vpe_pkg::VPE_SUSTAIN: begin
                    next_st.level = st.level;
                end
                // fall to silence, then go idle
                vpe_pkg::VPE_RELEASE: begin
                    if (st.level == vpe_pkg::ZERO_LEVEL) begin
                        next_st.phase = vpe_pkg::VPE_IDLE;
                    end else begin
                        next_st.level = st.level - 8'h01;
                    end
                end
                vpe_pkg::VPE_IDLE: begin
                    next_st.level = vpe_pkg::ZERO_LEVEL;
                end
            endcase
        end

        next_st.busy = (next_st.phase != vpe_pkg::VPE_IDLE);
    end

    // register, synchronous reset, frozen by clock enable
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st.freq     <= {vpe_pkg::RST_BYTE, vpe_pkg::RST_BYTE};
            st.key_on   <= 1'b0;
            st.key_prev <= 1'b0;
            st.atk      <= 4'h0;
            st.dec      <= 4'h0;
            st.sus      <= 4'h0;
            st.rel      <= 4'h0;
            st.phase    <= vpe_pkg::VPE_IDLE;
            st.level    <= vpe_pkg::RST_LEVEL;
            st.rdata    <= vpe_pkg::RST_BYTE;
            st.osc_out  <= '0;
            st.busy     <= 1'b0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign reg_rdata = st.rdata;
    assign osc_phase = st.osc_out;
    assign env_level = st.level;
    assign env_busy  = st.busy;

endmodule : vpe_voice

// File: test/vpe_voice_assertions.sv
// port checker for the voice block, bound onto every instance
`timescale 1ns/10ps
// ==========================================================
// checker
module vpe_voice_chk #(
    parameter int unsigned MS_CYC = 255,  // mclk cycles per millisecond
    parameter int unsigned DIV    = 4     // mclk cycles per master tick
) (
    // clock, reset, enable
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        ce,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // voice outputs
    input wire logic [11:0] osc_phase,
    input wire logic [7:0]  env_level,
    input wire logic        env_busy
);
    logic        key;  // key-on bit as last written
    logic [3:0]  sus;  // sustain nibble as last written
    logic [15:0] fw;   // frequency word as last written
    logic [7:0]  age;  // cycles since osc_phase last moved, saturating

    // shadow the settings the host has written
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            key <= 1'b0;
            sus <= 4'h0;
            fw  <= 16'h0000;
            age <= 8'hff;
        end else if (ce) begin
            if (reg_wr && reg_addr == 4'h2) key <= reg_wdata[0];
            if (reg_wr && reg_addr == 4'h4) sus <= reg_wdata[7:4];
            if (reg_wr && reg_addr == 4'h0) fw[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == 4'h1) fw[15:8] <= reg_wdata;
            age <= $changed(osc_phase) ? 8'h01 : ((age == 8'hff) ? age : age + 8'h01);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_read_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_unmapped_read: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    chk_level_step: assert property ($changed(env_level) |-> env_level == $past(env_level) + 8'h01 || env_level == $past(env_level) - 8'h01)
        else $error("envelope level jumped");
    chk_key_start: assert property ($rose(key) |=> env_busy)
        else $error("key-on did not start the envelope");
    chk_release_fall: assert property (!key && !$past(key) |-> env_level <= $past(env_level))
        else $error("level rose with key off");
    chk_sustain_floor: assert property (key && $past(key) && env_level < {sus, sus} |-> env_level >= $past(env_level))
        else $error("level fell below sustain with key held");
    chk_busy_end: assert property ($fell(env_busy) |-> env_level == 8'h00 && !key)
        else $error("envelope went idle early");
    chk_osc_pace: assert property ($changed(osc_phase) |-> age >= DIV)
        else $error("oscillator stepped faster than the master tick");
    chk_osc_still: assert property ((fw == 16'h0000) [*2] |=> $stable(osc_phase))
        else $error("oscillator moved with a zero word");

    // main scenarios reached
    cov_start: cover property ($rose(env_busy));
    cov_end: cover property ($fell(env_busy));
    cov_unmapped: cover property (reg_rd && reg_addr[3]);
endmodule : vpe_voice_chk

bind vpe_voice vpe_voice_chk #(.MS_CYC(MS_CYC), .DIV(DIV)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_phase(osc_phase),
    .env_level(env_level), .env_busy(env_busy)
);

// File: test/vpe_host_model.sv
// host processor model: writes and reads the voice registers
`timescale 1ns/10ps
// ==========================================================
// host bus master
module vpe_host_model (
    // clock
    input wire logic  mclk,
    // register port
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd
);
    // quiet bus at time zero
    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one-cycle write; idle lines flip so no stale value looks valid
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    // one-cycle read; data is picked up by the bench monitor
    task rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
    endtask : rd

    // frequency word, confined to 16 bits by its type
    task fw(input logic [15:0] f);
        wr(4'h0, f[7:0]);
        wr(4'h1, f[15:8]);
    endtask : fw
endmodule : vpe_host_model

// File: test/tb.sv
// self-checking bench for the voice pitch and envelope block
`timescale 1ns/10ps
// ==========================================================
// bench top
module tb;
    localparam int unsigned MSC   = 255;     // one cycle per ms-step unit
    localparam int unsigned DV    = 4;       // short master tick
    localparam int          LIMIT = 100000;  // cycle ceiling for the run
    logic        mclk, reset_n, ce, reg_wr, reg_rd, rd_q;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, env_level, v;
    logic [11:0] osc_phase;
    logic        env_busy;
    int          mismatches, checks_done, cyc, n;
    logic [7:0]  expq[$];  // expected read data, oldest first

    vpe_host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    vpe_voice #(.MS_CYC(MSC), .DIV(DV)) u_dut (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .osc_phase(osc_phase), .env_level(env_level),
        .env_busy(env_busy));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // read with its expected value noted first
    task rd(input logic [3:0] a, input logic [7:0] e);
        expq.push_back(e);
        u_host.rd(a);
    endtask : rd

    // wait for a given level; n counts cycles
    task till(input logic [7:0] t);
        n = 0;
        while (env_level !== t) begin @(negedge mclk); n++; end
    endtask : till

    // length of one full level step
    task gap;
        v = env_level;
        while (env_level === v) @(negedge mclk);
        v = env_level;
        n = 0;
        while (env_level === v) begin @(negedge mclk); n++; end
    endtask : gap

    // one oscillator period measured on the top phase bit
    task osc(input logic [15:0] f);
        int e;
        u_host.fw(f);
        e = (2 ** 24) * DV / f;
        for (int i = 0; i < 2; i++) begin
            n = 0;
            while (osc_phase[11] === 1'b1) begin @(negedge mclk); n++; end
            while (osc_phase[11] === 1'b0) begin @(negedge mclk); n++; end
        end
        check((n >= e - DV) && (n <= e + DV), 1'b1);
    endtask : osc

    // read data monitor: one note per read
    always @(posedge mclk) rd_q <= reg_rd && reset_n;
    always @(negedge mclk) if (rd_q) check(reg_rdata, expq.pop_front());

    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            results();
        end
    end

    initial begin
        {ce, reset_n, rd_q, mismatches, checks_done, cyc} = {3'b100, 96'h0};
        void'($urandom(32'haca3));
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        // registers: reset values, read-back, read-only and unmapped places
        for (int a = 0; a < 8; a++) rd(4'(a), (a == 7) ? 8'h01 : 8'h00);
        foreach (expq[i]) ;
        for (int a = 0; a < 5; a++) begin
            v = 8'($urandom);
            if (a != 2) u_host.wr(4'(a), v);
            if (a != 2) rd(4'(a), v);
        end
        u_host.wr(4'h5, 8'h5a);
        rd(4'h5, 8'h00);
        rd(4'h8 + 4'($urandom_range(7)), 8'h00);
        $display("registers test done");
        osc(16'd59056);
        osc(16'd29528);
        osc(16'd3691);
        $display("oscillator test done");
        // full envelope with timed phases and a re-press in release
        u_host.wr(4'h3, 8'ha8);
        u_host.wr(4'h4, 8'he9);
        u_host.wr(4'h2, 8'h01);
        gap();
        check(n, 500 * MSC / 255);
        rd(4'h7, 8'h02);
        u_host.wr(4'h3, 8'h08);
        till(8'hff);
        gap();
        check(n, 300 * MSC / 255);
        rd(4'h7, 8'h04);
        till(8'hee);
        repeat (2000) @(negedge mclk);
        check(env_level, 8'hee);
        rd(4'h7, 8'h08);
        u_host.wr(4'h2, 8'h00);
        gap();
        check(n, 750 * MSC / 255);
        u_host.wr(4'h3, 8'ha8);
        u_host.wr(4'h2, 8'h01);
        repeat (4) @(negedge mclk);
        rd(4'h7, 8'h02);
        check(env_level, 8'hec);
        gap();
        check(env_level, v + 8'h01);
        u_host.wr(4'h4, 8'he0);
        u_host.wr(4'h2, 8'h00);
        till(8'h00);
        repeat (8) @(negedge mclk);
        check(env_busy, 1'b0);
        rd(4'h7, 8'h01);
        $display("envelope sequence test done");
        // fastest attack and release, full scale
        u_host.wr(4'h3, 8'h00);
        u_host.wr(4'h4, 8'hf0);
        u_host.wr(4'h2, 8'h01);
        till(8'hff);
        check((n >= 255 * 2 * MSC / 255) && (n <= 255 * 2 * MSC / 255 + 4), 1'b1);
        u_host.wr(4'h2, 8'h00);
        till(8'h00);
        check((n >= 6 * 255 * MSC / 255) && (n <= 6 * 255 * MSC / 255 + 4), 1'b1);
        $display("fast envelope test done");
        // zero sustain: silent after the peak with the key still held
        u_host.wr(4'h4, 8'h00);
        u_host.wr(4'h2, 8'h01);
        till(8'hff);
        till(8'h00);
        repeat (20) @(negedge mclk);
        check(env_level, 8'h00);
        rd(4'h5, 8'h00);
        u_host.wr(4'h2, 8'h00);
        $display("zero sustain test done");
        // key-off in mid-decay releases from the present level
        u_host.wr(4'h3, 8'h09);
        u_host.wr(4'h4, 8'h80);
        u_host.wr(4'h2, 8'h01);
        till(8'hfd);
        u_host.wr(4'h2, 8'h00);
        repeat (4) @(negedge mclk);
        rd(4'h7, 8'h10);
        gap();
        check(n, 6 * MSC / 255);
        // clock enable low freezes the envelope and the oscillator
        @(posedge mclk) ce <= 1'b0;
        @(negedge mclk) v = env_level;
        n = osc_phase;
        repeat (40) @(negedge mclk);
        check(env_level, v);
        check(osc_phase, n);
        @(posedge mclk) ce <= 1'b1;
        till(8'h00);
        $display("decay abort test done");
        repeat (4) @(negedge mclk);
        results();
    end
endmodule : tb
